/* File: src/fpxa_exp_align.sv */
// exponent compare, alignment control and rounding request for floating add/subtract
// Behaviour
// - flag far out of range when the exponent difference magnitude exceeds two to the seventeenth.
// - flag a second out-of-range case when that magnitude exceeds two to the seventeenth minus one.
// - flag positive ordering when both exponents are positive and the operand one is larger.
// - flag negative ordering when both exponents are negative and the accumulator one is more negative.
// - raise alignment-stop in the exponent phase when the difference exceeds 35 or is zero, and in the align phase when alignment is done.
// - in the exponent phase copy the operand exponent into the accumulator exponent when it is the larger.
// - flag a subtraction of unlike signs, which is carried out as an addition of magnitudes.
// - flag a subtraction of like signs as an effective subtraction of magnitudes.
// - at the first time state of the fraction phase request a rounding increment when alignment calls for it.
// - round the accumulator mantissa only when the guard bit is set as rounding is requested.
// - indicate same sign when both signs are positive or both negative.
// - pulse a load of the shift counter with the number of alignment shifts needed.
`timescale 1ns/1ns
`default_nettype none
`include "fpxa_cfg.svh"

module fpxa_exp_align
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire fpxa_pkg::fpxa_req_s req_in,
  input wire logic round_req_in,
  output logic busy_out,
  output logic done_out,
  output logic [`FPXA_SCALE_W-1:0] accumulator_scale_out,
  output logic [`FPXA_MANT_W-1:0] accumulator_mantissa_out,
  output logic [`FPXA_MANT_W-1:0] operand_mantissa_out,
  output logic guard_out,
  output var fpxa_pkg::fpxa_flags_s flags_out,
  output logic align_stop_out,
  output logic copy_operand_scale_out,
  output logic shift_count_load_pulse_out,
  output logic rounding_increment_request_out,
  output logic mantissa_rounding_pulse_out
);

  fpxa_pkg::fpxa_state_s st_ff;
  fpxa_pkg::fpxa_state_s nxt_st;
  fpxa_pkg::fpxa_cmp_s cmp;
  logic [`FPXA_MANT_W-1:0] acc_shr;
  logic [`FPXA_MANT_W-1:0] opd_shr;

  // compare runs on the latched scales, so its result is ready one phase later
  fpxa_scale_cmp fpxa_scale_cmp_inst
  (
    .clk_in(clk_in),
    .nrst_in(nrst_in),
    .acc_scale_in(st_ff.accumulator_scale),
    .opd_scale_in(st_ff.operand_scale),
    .cmp_out(cmp)
  );

  // one-place right shift of both fractions, zero filled from the top;
  // the bit that drops off the bottom becomes the guard bit
  generate
    for (genvar i = 0; i < `FPXA_MANT_W; i++)
    begin : g_shr
      if (i == `FPXA_MANT_W - 1)
      begin : g_top
        assign acc_shr[i] = 1'b0;
        assign opd_shr[i] = 1'b0;
      end
      else
      begin : g_low
        assign acc_shr[i] = st_ff.accumulator_mantissa[i + 1];
        assign opd_shr[i] = st_ff.operand_mantissa[i + 1];
      end
    end
  endgenerate

  // phase sequence: idle takes a start, compare lets the registered
  // difference settle, exponent sets flags and shift count, align
  // shifts one place per cycle, fraction raises done.
  // start and rounding are ignored while busy with no refusal sign,
  // so the caller must wait for done.
  always_comb
  begin
    logic same;
    same = (st_ff.acc_sign == st_ff.opd_sign);
    nxt_st = st_ff;
    nxt_st.align_stop = 1'b0;
    nxt_st.copy_operand_scale = 1'b0;
    nxt_st.shift_count_load_pulse = 1'b0;
    nxt_st.rounding_increment_request = 1'b0;
    nxt_st.mantissa_rounding_pulse = 1'b0;
    nxt_st.done = 1'b0;
    case (st_ff.phase)
      fpxa_pkg::PH_IDLE:
      begin
        if (req_in.start)
        begin
          nxt_st.phase = fpxa_pkg::PH_CMP;
          nxt_st.sub_op = req_in.subtract;
          nxt_st.acc_sign = req_in.acc_sign;
          nxt_st.opd_sign = req_in.opd_sign;
          nxt_st.accumulator_scale = req_in.accumulator_scale;
          nxt_st.operand_scale = req_in.operand_scale;
          nxt_st.accumulator_mantissa = req_in.accumulator_mantissa;
          nxt_st.operand_mantissa = req_in.operand_mantissa;
          nxt_st.guard = 1'b0;
          nxt_st.flags = '0;
        end
        else if (round_req_in && st_ff.guard)
        begin
          // rounding only acts when the guard bit holds a one
          nxt_st.accumulator_mantissa = st_ff.accumulator_mantissa + `FPXA_MANT_W'(1);
          nxt_st.mantissa_rounding_pulse = 1'b1;
          nxt_st.guard = 1'b0;
        end
      end
      fpxa_pkg::PH_CMP:
      begin
        // wait here for the registered compare result
        nxt_st.phase = fpxa_pkg::PH_EXP;
      end
      fpxa_pkg::PH_EXP:
      begin
        nxt_st.flags.range_far = cmp.far;
        nxt_st.flags.range_far_m1 = cmp.far_m1;
        nxt_st.flags.pos_order = cmp.pos_order;
        nxt_st.flags.neg_order = cmp.neg_order;
        nxt_st.flags.same_sign = same;
        nxt_st.flags.sub_unlike = st_ff.sub_op && !same;
        nxt_st.flags.sub_like = st_ff.sub_op && same;
        nxt_st.shift_acc = cmp.opd_greater;
        nxt_st.shift_count_load_pulse = 1'b1;
        nxt_st.shift_count = cmp.over_align ? '0 : cmp.diff_mag[`FPXA_SC_W-1:0];
        if (cmp.opd_greater)
        begin
          nxt_st.accumulator_scale = st_ff.operand_scale;
          nxt_st.copy_operand_scale = 1'b1;
        end
        if (cmp.over_align || cmp.diff_mag == '0)
        begin
          // too far apart: the smaller fraction would shift out entirely
          if (cmp.over_align && cmp.opd_greater)
          begin
            nxt_st.accumulator_mantissa = '0;
            nxt_st.guard = 1'b0;
          end
          else if (cmp.over_align)
          begin
            nxt_st.operand_mantissa = '0;
            nxt_st.guard = 1'b0;
          end
          nxt_st.align_stop = 1'b1;
          nxt_st.phase = fpxa_pkg::PH_FUN;
        end
        else
          nxt_st.phase = fpxa_pkg::PH_ALIGN;
      end
      fpxa_pkg::PH_ALIGN:
      begin
        if (st_ff.shift_acc)
        begin
          nxt_st.guard = st_ff.accumulator_mantissa[0];
          nxt_st.accumulator_mantissa = acc_shr;
        end
        else
        begin
          nxt_st.guard = st_ff.operand_mantissa[0];
          nxt_st.operand_mantissa = opd_shr;
        end
        nxt_st.shift_count = st_ff.shift_count - `FPXA_SC_ONE;
        if (st_ff.shift_count == `FPXA_SC_ONE)
        begin
          nxt_st.align_stop = 1'b1;
          nxt_st.phase = fpxa_pkg::PH_FUN;
        end
      end
      fpxa_pkg::PH_FUN:
      begin
        // first time state of the fraction phase
        nxt_st.rounding_increment_request = st_ff.guard;
        nxt_st.done = 1'b1;
        nxt_st.phase = fpxa_pkg::PH_IDLE;
      end
      default:
      begin
        nxt_st.phase = fpxa_pkg::PH_IDLE;
      end
    endcase
    // busy has its own flop so the port is a clean register output
    nxt_st.busy = (nxt_st.phase != fpxa_pkg::PH_IDLE);
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      st_ff <= '0;
    else
      st_ff <= nxt_st;
  end

  // every port is a plain copy of a state flop
  assign busy_out = st_ff.busy;
  assign done_out = st_ff.done;
  assign accumulator_scale_out = st_ff.accumulator_scale;
  assign accumulator_mantissa_out = st_ff.accumulator_mantissa;
  assign operand_mantissa_out = st_ff.operand_mantissa;
  assign guard_out = st_ff.guard;
  assign flags_out = st_ff.flags;
  assign align_stop_out = st_ff.align_stop;
  assign copy_operand_scale_out = st_ff.copy_operand_scale;
  assign shift_count_load_pulse_out = st_ff.shift_count_load_pulse;
  assign rounding_increment_request_out = st_ff.rounding_increment_request;
  assign mantissa_rounding_pulse_out = st_ff.mantissa_rounding_pulse;

endmodule

`default_nettype wire

/* File: src/fpxa_cfg.svh */
// constants for the floating add exponent compare and alignment block
`ifndef FPXA_CFG_SVH
`define FPXA_CFG_SVH

`define FPXA_SCALE_W 18
`define FPXA_DIFF_W 19
`define FPXA_MANT_W 36
`define FPXA_SC_W 6
`define FPXA_RANGE_LIMIT 19'h2_0000
`define FPXA_RANGE_LIMIT_M1 19'h1_FFFF
`define FPXA_ALIGN_LIMIT 19'h0_0023
`define FPXA_SC_ONE 6'h01

`endif

/* File: src/fpxa_pkg.sv */
// types for the floating add exponent compare and alignment block
`include "fpxa_cfg.svh"

package fpxa_pkg;

  typedef enum logic [2:0]
  {
    PH_IDLE,
    PH_CMP,
    PH_EXP,
    PH_ALIGN,
    PH_FUN
  } fpxa_phase_e;

  typedef struct packed {
    logic far;
    logic far_m1;
    logic pos_order;
    logic neg_order;
    logic opd_greater;
    logic over_align;
    logic [`FPXA_DIFF_W-1:0] diff_mag;
  } fpxa_cmp_s;

  typedef struct packed {
    logic range_far;
    logic range_far_m1;
    logic pos_order;
    logic neg_order;
    logic same_sign;
    logic sub_unlike;
    logic sub_like;
  } fpxa_flags_s;

  typedef struct packed {
    logic start;
    logic subtract;
    logic acc_sign;
    logic opd_sign;
    logic [`FPXA_SCALE_W-1:0] accumulator_scale;
    logic [`FPXA_SCALE_W-1:0] operand_scale;
    logic [`FPXA_MANT_W-1:0] accumulator_mantissa;
    logic [`FPXA_MANT_W-1:0] operand_mantissa;
  } fpxa_req_s;

  typedef struct packed {
    fpxa_phase_e phase;
    logic sub_op;
    logic acc_sign;
    logic opd_sign;
    logic [`FPXA_SCALE_W-1:0] accumulator_scale;
    logic [`FPXA_SCALE_W-1:0] operand_scale;
    logic [`FPXA_MANT_W-1:0] accumulator_mantissa;
    logic [`FPXA_MANT_W-1:0] operand_mantissa;
    logic guard;
    logic [`FPXA_SC_W-1:0] shift_count;
    logic shift_acc;
    fpxa_flags_s flags;
    logic align_stop;
    logic copy_operand_scale;
    logic shift_count_load_pulse;
    logic rounding_increment_request;
    logic mantissa_rounding_pulse;
    logic busy;
    logic done;
  } fpxa_state_s;

endpackage

/* File: src/fpxa_scale_cmp.sv */
// registered comparison of the two exponents
`timescale 1ns/1ns
`default_nettype none
`include "fpxa_cfg.svh"

module fpxa_scale_cmp
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic [`FPXA_SCALE_W-1:0] acc_scale_in,
  input wire logic [`FPXA_SCALE_W-1:0] opd_scale_in,
  output var fpxa_pkg::fpxa_cmp_s cmp_out
);

  fpxa_pkg::fpxa_cmp_s cmp_ff;
  fpxa_pkg::fpxa_cmp_s nxt_cmp;

  always_comb
  begin
    logic signed [`FPXA_DIFF_W-1:0] diff;
    logic [`FPXA_DIFF_W-1:0] mag;
    diff = $signed({acc_scale_in[`FPXA_SCALE_W-1], acc_scale_in})
         - $signed({opd_scale_in[`FPXA_SCALE_W-1], opd_scale_in});
    mag = diff[`FPXA_DIFF_W-1] ? `FPXA_DIFF_W'(-diff) : `FPXA_DIFF_W'(diff);
    nxt_cmp = '0;
    nxt_cmp.diff_mag = mag;
    nxt_cmp.far = (mag > `FPXA_RANGE_LIMIT);
    nxt_cmp.far_m1 = (mag > `FPXA_RANGE_LIMIT_M1);
    nxt_cmp.opd_greater = diff[`FPXA_DIFF_W-1];
    nxt_cmp.pos_order = !acc_scale_in[`FPXA_SCALE_W-1] && !opd_scale_in[`FPXA_SCALE_W-1]
                        && diff[`FPXA_DIFF_W-1];
    nxt_cmp.neg_order = acc_scale_in[`FPXA_SCALE_W-1] && opd_scale_in[`FPXA_SCALE_W-1]
                        && diff[`FPXA_DIFF_W-1];
    nxt_cmp.over_align = (mag > `FPXA_ALIGN_LIMIT);
  end

  always_ff @(posedge clk_in or negedge nrst_in)
  begin
    if (!nrst_in)
      cmp_ff <= '0;
    else
      cmp_ff <= nxt_cmp;
  end

  assign cmp_out = cmp_ff;

endmodule

`default_nettype wire

/* File: test/fpxa_exp_align_assertions.sv */
// concurrent checks on the exponent align block ports
`timescale 1ns/1ns
`default_nettype none
module fpxa_exp_align_chk
(
  input wire logic clk_in,
  input wire logic nrst_in,
  input wire logic busy_out,
  input wire logic done_out,
  input wire logic guard_out,
  input wire fpxa_pkg::fpxa_flags_s flags_out,
  input wire logic align_stop_out,
  input wire logic copy_operand_scale_out,
  input wire logic shift_count_load_pulse_out,
  input wire logic rounding_increment_request_out,
  input wire logic mantissa_rounding_pulse_out
);
  default clocking cb @(posedge clk_in);
  endclocking
  default disable iff (!nrst_in);
  load_after_start_a:
    assert property ($rose(busy_out) |-> ##2 shift_count_load_pulse_out) else $error("shift count load missing");
  copy_with_load_a:
    assert property (copy_operand_scale_out |-> shift_count_load_pulse_out && busy_out) else $error("stray copy");
  stop_then_done_a:
    assert property (align_stop_out |=> done_out) else $error("no finish after stop");
  increment_at_done_a:
    assert property (rounding_increment_request_out |-> done_out) else $error("increment off fraction step");
  round_guard_a:
    assert property (mantissa_rounding_pulse_out |-> $past(guard_out) && !busy_out) else $error("round without guard");
  range_nest_a:
    assert property (flags_out.range_far |-> flags_out.range_far_m1) else $error("range flags disagree");
  unlike_sign_a:
    assert property (flags_out.sub_unlike |-> !flags_out.same_sign) else $error("unlike flag with like signs");
  done_bound_a:
    assert property ($rose(busy_out) |-> ##[3:40] done_out) else $error("operation too long");
  cover property (align_stop_out && !shift_count_load_pulse_out);
  cover property (mantissa_rounding_pulse_out);
  cover property (copy_operand_scale_out);
endmodule
bind fpxa_exp_align fpxa_exp_align_chk fpxa_exp_align_chk_inst
(
  .clk_in(clk_in),
  .nrst_in(nrst_in),
  .busy_out(busy_out),
  .done_out(done_out),
  .guard_out(guard_out),
  .flags_out(flags_out),
  .align_stop_out(align_stop_out),
  .copy_operand_scale_out(copy_operand_scale_out),
  .shift_count_load_pulse_out(shift_count_load_pulse_out),
  .rounding_increment_request_out(rounding_increment_request_out),
  .mantissa_rounding_pulse_out(mantissa_rounding_pulse_out)
);
`default_nettype wire

/* File: test/fpxa_exp_align_tb.sv */
// self-checking bench for the exponent align block
`timescale 1ns/1ns
`default_nettype none
module fpxa_exp_align_tb;
  logic clk_in = 1'b0;
  logic nrst_in = 1'b0;
  logic round_req_in = 1'b0;
  fpxa_pkg::fpxa_req_s req = '0;
  fpxa_pkg::fpxa_flags_s flags;
  logic busy, done, guard, stop, copy, load, incr, rpulse;
  logic [17:0] scale;
  logic [35:0] am, bm;
  int errors = 0;
  int checked = 0;
  int loads = 0;
  int copies = 0;
  int stops = 0;
  always #5 clk_in = ~clk_in;
  fpxa_exp_align fpxa_exp_align_inst
  (
    .clk_in(clk_in), .nrst_in(nrst_in), .req_in(req), .round_req_in(round_req_in), .busy_out(busy),
    .done_out(done), .accumulator_scale_out(scale), .accumulator_mantissa_out(am), .operand_mantissa_out(bm),
    .guard_out(guard), .flags_out(flags), .align_stop_out(stop), .copy_operand_scale_out(copy),
    .shift_count_load_pulse_out(load), .rounding_increment_request_out(incr), .mantissa_rounding_pulse_out(rpulse)
  );
  task automatic end_of_test;
    $display("errors %0d checked %0d", errors, checked);
    if (errors == 0 && checked > 0)
      $display("Simulation passed");
    else
      $display("Simulation failed");
    $finish;
  endtask
  task automatic check(input logic [35:0] seen, input logic [35:0] exp);
    checked++;
    if (seen !== exp)
    begin
      errors++;
      $display("wrong value at %0t: seen %h expected %h", $time, seen, exp);
    end
  endtask
  // sg is subtract, accumulator sign, operand sign; returns in the done cycle
  task automatic op(input logic [17:0] a, input logic [17:0] b, input logic [35:0] ma, input logic [35:0] mb,
    input logic [2:0] sg, input logic [35:0] n_exp);
    int n;
    n = 0;
    loads = 0;
    copies = 0;
    stops = 0;
    @(posedge clk_in);
    req <= '{1'b1, sg[2], sg[1], sg[0], a, b, ma, mb};
    @(posedge clk_in);
    req.start <= 1'b0;
    do
    begin
      @(negedge clk_in);
      n++;
      if (n == 1)
        check(36'(busy), 36'h0_0000_0001);
      if (load !== 1'b0)
        loads++;
      if (copy !== 1'b0)
        copies++;
      if (stop !== 1'b0)
        stops++;
    end while (done !== 1'b1 && n < 50);
    if (done !== 1'b1)
    begin
      errors++;
      end_of_test();
    end
    else
    begin
      check(36'(n), n_exp);
      check(36'(busy), 36'h0_0000_0000);
      check(36'(loads), 36'h0_0000_0001);
      check(36'(stops), 36'h0_0000_0001);
    end
  endtask
  task automatic rnd(input logic [35:0] m_exp, input logic p_exp);
    @(posedge clk_in);
    round_req_in <= 1'b1;
    @(posedge clk_in);
    round_req_in <= 1'b0;
    @(negedge clk_in);
    check(am, m_exp);
    check(36'(rpulse), 36'(p_exp));
  endtask
  task automatic s_align;
    op(18'h0_0005, 18'h0_0007, 36'h0_0000_0006, 36'h0_0000_0009, 3'h0, 36'h0_0000_0006);
    check(36'(scale), 36'h0_0000_0007);
    check(am, 36'h0_0000_0001);
    check(36'(incr), 36'h0_0000_0001);
    check(36'(guard), 36'h0_0000_0001);
    check(36'(flags), 36'h0_0000_0014);
    check(36'(copies), 36'h0_0000_0001);
    rnd(36'h0_0000_0002, 1'b1);
    check(36'(guard), 36'h0_0000_0000);
    rnd(36'h0_0000_0002, 1'b0);
  endtask
  task automatic s_rev;
    op(18'h0_0007, 18'h0_0005, 36'h0_0000_0010, 36'h0_0000_0003, 3'h0, 36'h0_0000_0006);
    check(36'(scale), 36'h0_0000_0007);
    check(bm, 36'h0_0000_0000);
    check(36'(flags), 36'h0_0000_0004);
    check(36'(copies), 36'h0_0000_0000);
  endtask
  task automatic s_neg;
    op(18'h3_FFF6, 18'h3_FFFD, 36'h0_0000_0080, 36'h0_0000_0001, 3'h0, 36'h0_0000_000B);
    check(36'(scale), 36'h0_0003_FFFD);
    check(am, 36'h0_0000_0001);
    check(36'(flags), 36'h0_0000_000C);
    check(36'(copies), 36'h0_0000_0001);
    check(36'(incr), 36'h0_0000_0000);
  endtask
  task automatic s_far;
    op(18'h3_0000, 18'h1_0000, 36'h0_0000_0005, 36'h0_0000_0005, 3'h0, 36'h0_0000_0004);
    check(36'(flags), 36'h0_0000_0024);
    check(36'(copies), 36'h0_0000_0001);
    check(am, 36'h0_0000_0000);
    op(18'h2_0000, 18'h0_0001, 36'h0_0000_0005, 36'h0_0000_0005, 3'h0, 36'h0_0000_0004);
    check(36'(flags), 36'h0_0000_0064);
  endtask
  // every add/subtract and sign pairing at equal scales
  task automatic s_signs;
    for (int i = 0; i < 8; i++)
    begin
      op(18'h0_0000, 18'h0_0000, 36'h0_0000_0001, 36'h0_0000_0001, 3'(i), 36'h0_0000_0004);
      check(36'(flags), 36'({i[1] == i[0], i[2] && i[1] != i[0], i[2] && i[1] == i[0]}));
      check(36'(copies), 36'h0_0000_0000);
    end
  endtask
  initial
  begin
    repeat (8) @(posedge clk_in);
    nrst_in <= 1'b1;
    s_align();
    s_rev();
    s_neg();
    s_far();
    s_signs();
    end_of_test();
  end
endmodule
`default_nettype wire
